// ==== design/readout_mode_context_regs.sv ====
// Readout engine driven by the per-context readout-mode registers.
// Assumes array data and the context select bit come from logic on i_ref_clk.
// Notes on behaviour
// - Context select 1 applies context B fields, 0 applies context A fields.
// - Binning bit set runs the array binned, halving rows and columns read.
// - Zoom enabled follows each row with zoom minus one blank rows, same length.
// - Pixel clock unchanged; pixels held zoom clocks; blank rows have line valid, zero data.
// - Zoom field 00/01/10/11 gives 2x/4x/8x/16x, used only with zoom enabled.
// - Single ADC halves the pixel rate against the master clock; otherwise full rate.
// - Oversize without show: border hidden, blanking grows by 8 rows and 8 pixels.
// - Oversize with show: border output, frame and line valid grow by 8.
// - Oversize adds a 4-pixel border on every side, 8 rows and columns.
// - Column skip enabled selects 2x/4x/8x/16x from its field; else normal.
// - Column mirror reads start+size downward, to start+1 without binning or skip; else start upward.
// - Row mirror reads start+size downward, to start+1 without binning or skip; else start upward.
`timescale 1ns/10ps
`include "readout_regs.svh"

module readout_mode_context_regs #(
	parameter int COL_START = 16,
	parameter int COL_SIZE  = 64,
	parameter int ROW_START = 16,
	parameter int ROW_SIZE  = 48,
	parameter int H_BLANK   = 8,
	parameter int V_BLANK   = 4
) (
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst,
	input  wire readout_pkg::reg_req_type i_reg_req,
	input  wire logic                   i_context_select_bit,
	input  wire logic [9:0]             i_array_data,
	output readout_pkg::reg_rsp_type    o_reg_rsp,
	output readout_pkg::video_type      o_video,
	output readout_pkg::mode_type       o_active_mode
);
	import readout_pkg::*;

	// Refuse geometry the counters cannot serve
	if (COL_SIZE < 32 || ROW_SIZE < 32 || H_BLANK < 1 || V_BLANK < 1 ||
	    COL_START + COL_SIZE > 65535 || ROW_START + ROW_SIZE > 65535 ||
	    COL_START < 4 || ROW_START < 4) begin : g_bad_geometry
		$error("readout geometry out of range");
	end

	localparam logic [15:0] C_START = 16'(COL_START);
	localparam logic [15:0] C_SIZE  = 16'(COL_SIZE);
	localparam logic [15:0] R_START = 16'(ROW_START);
	localparam logic [15:0] R_SIZE  = 16'(ROW_SIZE);
	localparam logic [15:0] H_BLK   = 16'(H_BLANK);
	localparam logic [15:0] V_BLK   = 16'(V_BLANK);

	engine_state_s_type q;
	engine_state_s_type d;
	mode_type           sel;
	mode_type           s;
	logic [2:0]         col_shift;
	logic [2:0]         row_shift;
	logic [15:0]        act_cols;
	logic [15:0]        act_rows;
	logic [4:0]         zf;
	logic [15:0]        border;
	logic               show;
	logic [15:0]        line_len;
	logic [15:0]        lv_len;
	logic [15:0]        frame_len;
	logic [15:0]        fv_len;
	logic               tick;
	logic               last_hold;
	logic               last_px;
	logic               last_rs;
	logic               last_ry;
	logic               wrap;
	logic               in_fv;
	logic               in_lv;
	logic [15:0]        cidx;
	logic [15:0]        ridx;
	logic [15:0]        col_step;
	logic [15:0]        row_step;

	readout_reg_bank u_bank (
		.i_ref_clk            (i_ref_clk),
		.i_rst                (i_rst),
		.i_reg_req            (i_reg_req),
		.i_context_select_bit (i_context_select_bit),
		.o_reg_rsp            (o_reg_rsp),
		.o_sel_mode           (sel)
	);

	// Frame geometry from the latched mode; show border from the live register
	assign s         = q.shadow;
	assign col_shift = {2'b00, s.binning} + (s.col_skip_en ? {1'b0, s.col_skip} + 3'd1 : 3'd0);
	assign row_shift = {2'b00, s.binning} + (s.row_skip_en ? {1'b0, s.row_skip} + 3'd1 : 3'd0);
	assign act_cols  = C_SIZE >> col_shift;
	assign act_rows  = R_SIZE >> row_shift;
	assign zf        = s.zoom_en ? (5'd2 << s.zoom) : 5'd1;
	assign border    = s.oversize ? `RMC_BORDER_TOTAL : 16'd0;
	// Show border is not frame synchronised, so it follows the live register
	assign show      = s.oversize & sel.show_border;
	assign line_len  = act_cols + border + H_BLK;
	assign frame_len = act_rows + border + V_BLK;
	assign lv_len    = act_cols + (show ? border : 16'd0);
	assign fv_len    = act_rows + (show ? border : 16'd0);

	// Pixel clock: every cycle, or every other cycle on one converter
	assign tick      = ~s.one_adc | q.div;
	assign last_hold = q.hold == zf - 5'd1;
	assign last_px   = q.px == line_len - 16'd1;
	assign last_rs   = q.rs == zf - 5'd1;
	assign last_ry   = q.ry == frame_len - 16'd1;
	assign wrap      = (q.st == ST_RUN) & tick & last_hold & last_px & last_rs & last_ry;

	// Window position and array addresses of the current pixel
	assign in_fv    = (q.st == ST_RUN) & (q.ry < fv_len);
	assign in_lv    = in_fv & (q.px < lv_len);
	assign cidx     = q.px - (show ? `RMC_BORDER_SIDE : 16'd0);
	assign ridx     = q.ry - (show ? `RMC_BORDER_SIDE : 16'd0);
	assign col_step = cidx << col_shift;
	assign row_step = ridx << row_shift;

	// Counter sequencing, frame-start latch and video outputs
	always_comb begin
		d = q;
		d.vid.frame_valid = in_fv;
		d.vid.line_valid  = in_lv;
		d.vid.blank_row   = in_fv & (q.rs != 5'd0);
		d.vid.pixel_tick  = (q.st == ST_RUN) & tick;
		d.vid.data        = (in_lv && q.rs == 5'd0) ? i_array_data : 10'h000;
		d.vid.col_addr    = s.col_mirror ? C_START + C_SIZE - col_step : C_START + col_step;
		d.vid.row_addr    = s.row_mirror ? R_START + R_SIZE - row_step : R_START + row_step;
		case (q.st)
			ST_LOAD: begin
				d.shadow = sel;
				d.st = ST_RUN;
				d.div = 1'b0;
				d.hold = 5'd0;
				d.px = 16'd0;
				d.rs = 5'd0;
				d.ry = 16'd0;
			end
			ST_RUN: begin
				d.div = s.one_adc ? ~q.div : 1'b0;
				if (tick) begin
					if (last_hold) begin
						d.hold = 5'd0;
						if (last_px) begin
							d.px = 16'd0;
							if (last_rs) begin
								d.rs = 5'd0;
								d.ry = last_ry ? 16'd0 : q.ry + 16'd1;
							end else begin
								d.rs = q.rs + 5'd1;
							end
						end else begin
							d.px = q.px + 16'd1;
						end
					end else begin
						d.hold = q.hold + 5'd1;
					end
				end
				if (wrap) begin
					d.shadow = sel;
					d.div = 1'b0;
				end
			end
			default: d.st = ST_LOAD;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_video       = q.vid;
	assign o_active_mode = q.shadow;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	a_shadow_load: assert property (wrap |=> (q.shadow == $past(sel)))
		else $error("mode not latched at frame start");

	a_shadow_stable: assert property ((q.st == ST_RUN && !wrap) |=> $stable(q.shadow))
		else $error("mode changed inside a frame");

	a_pixel_hold: assert property ((q.st == ST_RUN && $past(q.st) == ST_RUN && q.px != $past(q.px))
		|-> ($past(q.hold) == $past(zf) - 5'd1))
		else $error("pixel not held for zoom factor clocks");

	a_zoom_slots: assert property ((q.st == ST_RUN) |-> (q.rs < zf && q.hold < zf))
		else $error("zoom slot counter past factor");

	a_blank_data: assert property (o_video.blank_row |-> (o_video.data == 10'h000))
		else $error("blank row carries data");

	a_half_rate: assert property ((q.st == ST_RUN && s.one_adc && tick && !wrap) |=> !tick)
		else $error("single converter tick too fast");

	a_full_rate: assert property ((q.st == ST_RUN && !s.one_adc) |-> tick)
		else $error("dual converter tick missing");

	a_line_bound: assert property ((q.st == ST_RUN) |-> (q.px < line_len && q.ry < frame_len))
		else $error("counter beyond line or frame length");

	a_col_mirror: assert property ((in_lv && q.px == 16'd0 && !show && s.col_mirror)
		|=> (o_video.col_addr == C_START + C_SIZE))
		else $error("mirrored column start wrong");

	a_row_normal: assert property ((in_fv && q.ry == 16'd0 && !show && !s.row_mirror)
		|=> (o_video.row_addr == R_START))
		else $error("normal row start wrong");

	// Last shown border pixel still inside line valid; hidden border falls in blanking
	a_border_shown: assert property ((in_fv && show && q.px == act_cols + `RMC_BORDER_TOTAL - 16'd1)
		|=> o_video.line_valid)
		else $error("shown border not in line valid");

	a_border_hidden: assert property ((in_fv && s.oversize && !show && q.px == act_cols)
		|=> !o_video.line_valid)
		else $error("hidden border inside line valid");

	c_zoom_blank: cover property (o_video.blank_row && o_video.line_valid);
	c_one_adc: cover property (q.st == ST_RUN && s.one_adc && in_lv);
	c_frame_wrap: cover property (wrap && s.oversize);
	c_mirror: cover property (in_lv && s.col_mirror && s.row_mirror);

endmodule

// ==== design/readout_regs.svh ====
// Register offsets, field positions, reset values and border counts of the readout-mode bank.
// Included by the design files; holds definitions only.
`ifndef READOUT_REGS_SVH
`define READOUT_REGS_SVH

// Register offsets on the sensor register port
`define RMC_OFS_CTX_B       8'h20
`define RMC_OFS_CTX_A       8'h21

// Reset values of the two context registers
`define RMC_RST_CTX_B       16'h0000
`define RMC_RST_CTX_A       16'h8490

// Writable bits; bit 14 is reserved and reads as zero
`define RMC_RW_MASK         16'hBFFF

// Field positions
`define RMC_BIT_BINNING     15
`define RMC_BIT_ZOOM_EN     13
`define RMC_BIT_ONE_ADC     10
`define RMC_BIT_SHOW_BORDER 9
`define RMC_BIT_OVERSIZE    8
`define RMC_BIT_COL_MIRROR  1
`define RMC_BIT_ROW_MIRROR  0

// Border geometry: pixels per side and total added per axis
`define RMC_BORDER_SIDE     16'd4
`define RMC_BORDER_TOTAL    16'd8

`endif

// ==== design/readout_pkg.sv ====
// Types shared by the readout-mode register bank and the readout engine.
// Offsets and reset values live in readout_regs.svh.
package readout_pkg;

	// Layout of one readout-mode context register
	typedef struct packed {
		logic       binning;
		logic       reserved;
		logic       zoom_en;
		logic [1:0] zoom;
		logic       one_adc;
		logic       show_border;
		logic       oversize;
		logic       col_skip_en;
		logic [1:0] col_skip;
		logic       row_skip_en;
		logic [1:0] row_skip;
		logic       col_mirror;
		logic       row_mirror;
	} mode_type;

	// Register port request and answer
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic        ack;
		logic [15:0] rdata;
	} reg_rsp_type;

	// Video side of the readout engine
	typedef struct packed {
		logic        frame_valid;
		logic        line_valid;
		logic        blank_row;
		logic        pixel_tick;
		logic [9:0]  data;
		logic [15:0] row_addr;
		logic [15:0] col_addr;
	} video_type;

	typedef enum logic [0:0] {
		ST_LOAD = 1'b0,
		ST_RUN  = 1'b1
	} engine_state_type;

	typedef struct packed {
		mode_type    ctx_b;
		mode_type    ctx_a;
		reg_rsp_type rsp;
	} bank_state_type;

	typedef struct packed {
		engine_state_type st;
		mode_type         shadow;
		logic             div;
		logic [4:0]       hold;
		logic [15:0]      px;
		logic [15:0]      ry;
		logic [4:0]       rs;
		video_type        vid;
	} engine_state_s_type;

endpackage

// ==== design/readout_reg_bank.sv ====
// Readout-mode register bank: two context registers on the sensor register port.
// Assumes requests come from logic on i_ref_clk; one request per cycle.
`timescale 1ns/10ps
`include "readout_regs.svh"

module readout_reg_bank (
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst,
	input  wire readout_pkg::reg_req_type i_reg_req,
	input  wire logic                   i_context_select_bit,
	output readout_pkg::reg_rsp_type    o_reg_rsp,
	output readout_pkg::mode_type       o_sel_mode
);
	import readout_pkg::*;

	bank_state_type q;
	bank_state_type d;

	// Register writes and read answers
	always_comb begin
		d = q;
		d.rsp.ack = i_reg_req.rd;
		d.rsp.rdata = 16'h0000;
		if (i_reg_req.rd) begin
			case (i_reg_req.addr)
				`RMC_OFS_CTX_B: d.rsp.rdata = q.ctx_b;
				`RMC_OFS_CTX_A: d.rsp.rdata = q.ctx_a;
				default:        d.rsp.rdata = 16'h0000; // Unmapped reads zero
			endcase
		end
		if (i_reg_req.wr) begin
			case (i_reg_req.addr)
				`RMC_OFS_CTX_B: d.ctx_b = mode_type'(i_reg_req.wdata & `RMC_RW_MASK);
				`RMC_OFS_CTX_A: d.ctx_a = mode_type'(i_reg_req.wdata & `RMC_RW_MASK);
				default:        d.ctx_b = q.ctx_b;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '{ctx_b: mode_type'(`RMC_RST_CTX_B), ctx_a: mode_type'(`RMC_RST_CTX_A), rsp: '0};
		end else begin
			q <= d;
		end
	end

	// Context select chooses which set steers readout
	assign o_sel_mode = i_context_select_bit ? q.ctx_b : q.ctx_a;
	assign o_reg_rsp  = q.rsp;

	a_write_ctx_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_reg_req.wr && i_reg_req.addr == `RMC_OFS_CTX_B) |=> (q.ctx_b == ($past(i_reg_req.wdata) & `RMC_RW_MASK)))
		else $error("context B write not stored");

	a_read_unmapped: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_reg_req.rd && i_reg_req.addr != `RMC_OFS_CTX_B && i_reg_req.addr != `RMC_OFS_CTX_A)
		|=> (o_reg_rsp.ack && o_reg_rsp.rdata == 16'h0000))
		else $error("unmapped read not zero");

endmodule

// ==== tb/reg_host_model.sv ====
// Host model that drives the sensor register port with single writes and reads.
// Assumes the bench calls its tasks; it changes signals only at the falling clock edge.
`timescale 1ns/10ps

module reg_host_model (
	input  wire logic                     i_ref_clk,
	output readout_pkg::reg_req_type      o_reg_req,
	input  wire readout_pkg::reg_rsp_type i_reg_rsp
);
	import readout_pkg::*;

	// Idle port shows no strobe
	initial o_reg_req = '0;

	// One-cycle write pulse; address and data inverted once released
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(negedge i_ref_clk) o_reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge i_ref_clk) o_reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// Read strobe for one cycle; data taken in the cycle that carries the answer
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(negedge i_ref_clk) o_reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge i_ref_clk) d = (i_reg_rsp.ack === 1'b1) ? i_reg_rsp.rdata : 16'hDEAD;
		o_reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
	endtask
endmodule

// ==== tb/tb_readout_mode_context_regs.sv ====
// Self-checking bench for the readout-mode engine: register access and frame geometry per mode.
// Assumes reg_host_model drives the register port; outputs are sampled at falling edges.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("FAIL %s expected %0h seen %0h", nm, (e), (g)); end end

module tb_readout_mode_context_regs;
	import readout_pkg::*;
	localparam int CS = 32;
	localparam int RS = 32;
	localparam int HB = 4;
	localparam int VB = 2;
	localparam int ST = 16;
	logic        clk;
	logic        i_rst;
	logic        sel;
	logic [9:0]  arr;
	logic [15:0] rd;
	logic [15:0] prev;
	reg_req_type req;
	reg_rsp_type rsp;
	video_type   vid;
	mode_type    act;
	int          err_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          modes[$] = '{'h0000, 'h8000, 'h0400, 'h0300, 'h0100, 'h0002, 'h0001, 'h0090, 'h00B4,
		'h00D8, 'h00FC, 'h20B4, 'h28B4, 'h30D8, 'h38FC};

	readout_mode_context_regs #(.COL_START(ST), .COL_SIZE(CS), .ROW_START(ST), .ROW_SIZE(RS),
		.H_BLANK(HB), .V_BLANK(VB)) uut (
		.i_ref_clk(clk), .i_rst(i_rst), .i_reg_req(req), .i_context_select_bit(sel),
		.i_array_data(arr), .o_reg_rsp(rsp), .o_video(vid), .o_active_mode(act));
	reg_host_model host (.i_ref_clk(clk), .o_reg_req(req), .i_reg_rsp(rsp));

	// Free-running clock and random array data
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) arr <= 10'($urandom);

	// Watchdog on total run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			err_count++;
			final_report();
		end
	end

	task automatic final_report;
		if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// One frame from rising frame window to the next; first line, line count, first address
	task automatic measure_and_check(input int v);
		int per, lines, len, sc, sr, zf, ov, sh, adc, n, ticks;
		logic lv0, fv0, first;
		logic [15:0] c0, r0;
		do @(negedge clk); while (vid.frame_valid !== 1'b0);
		do @(negedge clk); while (vid.frame_valid !== 1'b1);
		{per, lines, len, lv0, fv0, first} = {32'd0, 32'd0, 32'd0, 3'b011};
		ticks = 0;
		while (!(vid.frame_valid === 1'b1 && !fv0)) begin
			if (vid.line_valid === 1'b1 && !lv0) begin
				lines++;
				if (first) {c0, r0} = {vid.col_addr, vid.row_addr};
			end
			if (vid.line_valid !== 1'b1 && lv0) first = 1'b0;
			if (first && vid.line_valid === 1'b1) len++;
			if (vid.pixel_tick === 1'b1) ticks++;
			// Blank rows carry zero; real rows pass the array value sampled at the last edge
			if (vid.blank_row === 1'b1) `CHK("blank_data", 10'h000, vid.data)
			else if (vid.line_valid === 1'b1) `CHK("pixel_data", arr, vid.data)
			lv0 = (vid.line_valid === 1'b1);
			fv0 = (vid.frame_valid === 1'b1);
			per++;
			@(negedge clk);
		end
		sc = v[15] + (v[7] ? v[6:5] + 1 : 0);
		sr = v[15] + (v[4] ? v[3:2] + 1 : 0);
		zf = v[13] ? 2 << v[12:11] : 1;
		ov = v[8];
		sh = v[8] & v[9];
		adc = v[10] + 1;
		n = ((RS >> sr) + ov * 8 + VB) * zf * ((CS >> sc) + ov * 8 + HB) * zf;
		`CHK("line_len", ((CS >> sc) + sh * 8) * zf * adc, len)
		`CHK("lines", ((RS >> sr) + sh * 8) * zf, lines)
		`CHK("period", n * adc, per)
		`CHK("ticks", n, ticks)
		`CHK("active_mode", 16'(v), act)
		if ((v & 'h8190) == 0) begin
			`CHK("first_col", 16'(v[1] ? ST + CS : ST), c0)
			`CHK("first_row", 16'(v[0] ? ST + RS : ST), r0)
		end
	endtask

	// Reset, defaults, then every mode through context B with context A scrambled
	initial begin
		void'($urandom(85));
		{i_rst, sel} = 2'b10;
		repeat (8) @(negedge clk);
		i_rst = 1'b0;
		host.read_reg(8'h20, rd);
		`CHK("ctx_b_reset", 16'h0000, rd)
		host.read_reg(8'h21, rd);
		`CHK("ctx_a_reset", 16'h8490, rd)
		host.read_reg(8'h33, rd);
		`CHK("unmapped", 16'h0000, rd)
		measure_and_check('h8490);
		sel = 1'b1;
		prev = 16'h8490;
		foreach (modes[i]) begin
			host.write_reg(8'h20, 16'(modes[i]) | 16'h4000);
			host.write_reg(8'h21, 16'($urandom));
			host.read_reg(8'h20, rd);
			`CHK("ctx_b_readback", 16'(modes[i]), rd)
			`CHK("mode_held", prev, act)
			measure_and_check(modes[i]);
			prev = 16'(modes[i]);
		end
		// Back to context A with a known mirrored mode
		host.write_reg(8'h21, 16'h0001);
		host.read_reg(8'h21, rd);
		`CHK("ctx_a_readback", 16'h0001, rd)
		sel = 1'b0;
		`CHK("mode_held", prev, act)
		measure_and_check('h0001);
		final_report();
	end
endmodule
